// *** dv/cpc_clock_power_control_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpc_clock_power_control_asserts #(
  parameter int NPERIPH = 4
) (
  input wire logic                 clk_sys,
  input wire logic                 rstn,
  input wire logic                 idleReq,
  input wire logic                 sleepReq,
  input wire logic                 pdownReq,
  input wire logic                 deepReq,
  input wire logic [NPERIPH-1:0]   periphGateEn,
  input wire logic                 cpuClkEn,
  input wire logic [NPERIPH-1:0]   periphClkEn,
  input wire cpc_pkg::cpc_status_t status
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_reset_rc_src: assert property (
    $rose(rstn) |-> status.srcActive == cpc_pkg::CPC_SRC_RC && !status.pllPowerOn && !status.pllConnected)
    else $error("reset left wrong source or PLL on");
  chk_idle_stops_cpu: assert property (
    idleReq && status.cpuRun && !sleepReq && !pdownReq && !deepReq |=> !status.cpuRun && status.rcOutEn)
    else $error("idle entry wrong");
  chk_sleep_entry: assert property (
    sleepReq && status.cpuRun && !pdownReq && !deepReq |=> !status.rcOutEn && status.rcPowerOn
      && status.flashPowerOn && !status.pllPowerOn && !status.pllConnected)
    else $error("sleep entry wrong");
  chk_pdown_entry: assert property (
    pdownReq && status.cpuRun && !deepReq |=> !status.rcPowerOn && !status.flashPowerOn && !status.pllPowerOn)
    else $error("power-down entry wrong");
  chk_no_cpu_tick: assert property (
    !status.cpuRun && !$past(status.cpuRun) |-> !cpuClkEn)
    else $error("cpu tick while stopped");
  chk_sleep_no_clk: assert property (
    !status.rcOutEn && !$past(status.rcOutEn) |-> periphClkEn == '0)
    else $error("peripheral tick with clocks gated");
  chk_gate_stops: assert property (
    !periphGateEn[0] && !$past(periphGateEn[0]) && !$past(periphGateEn[0], 2) |-> !periphClkEn[0])
    else $error("gated peripheral ticked");
  chk_main_stable: assert property (
    status.srcActive == cpc_pkg::CPC_SRC_MAIN && status.cpuRun |-> status.mainStable)
    else $error("main used before stable");
endmodule
bind cpc_clock_power_control cpc_clock_power_control_asserts #(.NPERIPH(NPERIPH)) u_asserts (
  .clk_sys(clk_sys), .rstn(rstn), .idleReq(idleReq), .sleepReq(sleepReq), .pdownReq(pdownReq),
  .deepReq(deepReq), .periphGateEn(periphGateEn), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
  .status(status));
`default_nettype wire

// *** dv/cpc_clock_power_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpc_clock_power_control_test;
  logic                 clk_sys = 1'b0;
  logic                 rstn = 1'b0;
  logic                 cfgWr = 1'b0;
  cpc_pkg::cpc_cfg_t    cfg = '0;
  logic [3:0]           modeReq = 4'h0;
  logic [3:0]           lvl = 4'h0;
  logic [3:0]           gateEn = 4'hF;
  logic                 rcOsc = 1'b0, mainOsc = 1'b0, rtcOsc = 1'b0, current_controlled_osc = 1'b0, cpuClkEn, usbClkEn;
  logic [3:0]           periphClkEn;
  logic                 pfdUp, pfdDown;
  cpc_pkg::cpc_status_t status;
  int                   nCpu, nP0, nP1, nUsb, nPfd, errors, n_checks, t;
  // Oscillator edges land on falling clock edges: RC 4 MHz, main 5 MHz, RTC 1 MHz, CURRENT_CONTROLLED_OSC tap 6.67 MHz.
  always #12.5 clk_sys = ~clk_sys;
  always #125 rcOsc = ~rcOsc;
  always #100 mainOsc = ~mainOsc;
  always #500 rtcOsc = ~rtcOsc;
  always #75 current_controlled_osc = ~current_controlled_osc;
  always @(posedge clk_sys) begin
    nCpu <= nCpu + cpuClkEn;
    nP0 <= nP0 + periphClkEn[0];
    nP1 <= nP1 + periphClkEn[1];
    nUsb <= nUsb + usbClkEn;
    nPfd <= nPfd + pfdUp + pfdDown;
  end
  cpc_clock_power_control #(.NPERIPH(4)) uut (
    .clk_sys(clk_sys), .rstn(rstn), .cfgWr(cfgWr), .cfg(cfg), .idleReq(modeReq[0]), .sleepReq(modeReq[1]),
    .pdownReq(modeReq[2]), .deepReq(modeReq[3]), .periphDivSel(8'h04), .periphGateEn(gateEn),
    .rcOscIn(rcOsc), .mainOscIn(mainOsc), .rtcOscIn(rtcOsc), .ccoIn(current_controlled_osc), .pllLockIn(lvl[0]),
    .irqIn(lvl[1]), .wakeIrqIn(lvl[2]), .rtcAlarmIn(lvl[3]), .cpuClkEn(cpuClkEn), .usbClkEn(usbClkEn),
    .periphClkEn(periphClkEn), .pfdUp(pfdUp), .pfdDown(pfdDown), .status(status));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic zero();
    nCpu = 0;
    nP0 = 0;
    nP1 = 0;
    nUsb = 0;
    nPfd = 0;
  endtask
  task automatic setCfg(input cpc_pkg::cpc_src_t src, input logic [2:0] bits);
    cfg.src = src;
    {cfg.mainOscEn, cfg.pllEn, cfg.pllConn} = bits;
    cfg.cpuDiv = 8'h01;
    cfg.usbDiv = 8'h01;
    cfgWr = 1'b1;
    cyc(1);
    cfgWr = 1'b0;
  endtask
  task automatic req(input int k);
    modeReq[k] = 1'b1;
    cyc(1);
    modeReq[k] = 1'b0;
  endtask
  task automatic waitRun(input int lim);
    for (t = 0; t < lim && status.cpuRun !== 1'b1; t++) cyc(1);
  endtask
  task automatic t_reset();
    chk({status.srcActive, status.pllPowerOn, status.pllConnected}, 4'h0);
    zero();
    cyc(400);
    chk(nCpu >= 39 && nCpu <= 41, 1'b1);
    chk(nP1 >= 19 && nP1 <= 21, 1'b1);
  endtask
  task automatic t_src();
    cpc_pkg::cpc_src_t s[3] = '{cpc_pkg::CPC_SRC_RTC, cpc_pkg::CPC_SRC_MAIN, cpc_pkg::CPC_SRC_RC};
    foreach (s[k]) begin
      setCfg(s[k], 3'h4);
      for (t = 0; t < 40000 && status.srcActive !== s[k]; t++) cyc(1);
      chk(status.srcActive, s[k]);
      if (s[k] == cpc_pkg::CPC_SRC_MAIN) chk(t > 32000, 1'b1);
    end
  endtask
  task automatic t_pll();
    setCfg(cpc_pkg::CPC_SRC_RC, 3'h7);
    cyc(60);
    chk(status.pllConnected, 1'b0);
    lvl[0] = 1'b1;
    for (t = 0; t < 60 && status.pllConnected !== 1'b1; t++) cyc(1);
    zero();
    cyc(300);
    chk(nCpu >= 49 && nCpu <= 51 && nUsb >= 49 && nUsb <= 51 && nPfd > 0, 1'b1);
  endtask
  task automatic t_sleep();
    req(1);
    chk({status.rcOutEn, status.pllPowerOn, status.pllConnected, status.flashPowerOn}, 4'h1);
    lvl[2] = 1'b1;
    waitRun(200);
    chk(t >= 30 && t < 200, 1'b1);
    lvl[2] = 1'b0;
    zero();
    cyc(100);
    chk(nCpu + nUsb + nPfd, 0);
    setCfg(cpc_pkg::CPC_SRC_RC, 3'h0);
  endtask
  task automatic t_idle();
    gateEn = 4'h1;
    req(0);
    zero();
    cyc(100);
    chk({nCpu == 0, nP0 >= 9, nP1 == 0}, 3'h7);
    lvl[1] = 1'b1;
    waitRun(10);
    chk(status.cpuRun, 1'b1);
    lvl[1] = 1'b0;
    gateEn = 4'hF;
  endtask
  task automatic t_pdown();
    req(2);
    chk({status.rcPowerOn, status.flashPowerOn, status.flashReady}, 3'h0);
    lvl[2] = 1'b1;
    waitRun(3500);
    chk({t >= 2400 && t < 3500, status.srcActive}, 3'h4);
    for (t = 0; t < 5000 && status.flashReady !== 1'b1; t++) cyc(1);
    chk(t > 0 && t < 5000, 1'b1);
    lvl[2] = 1'b0;
  endtask
  task automatic t_deep();
    req(3);
    chk({status.resetReq, status.regulatorOn}, 2'h0);
    lvl[3] = 1'b1;
    for (t = 0; t < 20 && status.resetReq !== 1'b1; t++) cyc(1);
    chk({status.resetReq, status.regulatorOn}, 2'h3);
    rstn = 1'b0;
    lvl[3] = 1'b0;
    cyc(5);
    rstn = 1'b1;
    t_reset();
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    cyc(5);
    rstn = 1'b1;
    t_reset();
    t_src();
    t_pll();
    t_sleep();
    t_idle();
    t_pdown();
    t_deep();
    tally_and_finish();
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** include/cpc_consts.svh ***
`ifndef CPC_CONSTS_SVH
`define CPC_CONSTS_SVH

// Rates in kHz, times in ns; 40 MHz system clock, 4 MHz RC oscillator.
`define CPC_CLK_KHZ 64'h9C40
`define CPC_RC_KHZ 64'hFA0
`define CPC_NS_PER_MS 64'hF4240
// 60 us RC oscillator start-up after Power-down.
`define CPC_IRC_START_NS 64'hEA60
// 100 us flash start-up.
`define CPC_FLASH_START_NS 64'h186A0
// Least times round up to whole cycles.
`define CPC_IRC_START_CLKS \
  ((`CPC_IRC_START_NS * `CPC_CLK_KHZ + `CPC_NS_PER_MS - 64'h1) / `CPC_NS_PER_MS)
`define CPC_FLASH_WAKE_RC \
  ((`CPC_FLASH_START_NS * `CPC_RC_KHZ + `CPC_NS_PER_MS - 64'h1) / `CPC_NS_PER_MS)
// Oscillator cycles before execution resumes.
`define CPC_RC_WAKE_CYC 3'h4
`define CPC_MAIN_WAKE_CYC 13'h1000

// Synchronised pin positions.
`define CPC_NPIN 8
`define CPC_PIN_RC 3'h0
`define CPC_PIN_MAIN 3'h1
`define CPC_PIN_RTC 3'h2
`define CPC_PIN_CCO 3'h3
`define CPC_PIN_LOCK 3'h4
`define CPC_PIN_IRQ 3'h5
`define CPC_PIN_WAKE 3'h6
`define CPC_PIN_ALARM 3'h7

`endif

// *** include/cpc_pkg.sv ***
package cpc_pkg;

  typedef enum logic [1:0] {
    CPC_SRC_RC,
    CPC_SRC_MAIN,
    CPC_SRC_RTC
  } cpc_src_t;

  // Divider fields hold N-1 and M-1; cpuDiv and usbDiv of zero stop that clock.
  typedef struct packed {
    cpc_src_t    src;
    logic        mainOscEn;
    logic        pllEn;
    logic        pllConn;
    logic [7:0]  preDiv;
    logic [14:0] mul;
    logic [7:0]  cpuDiv;
    logic [7:0]  usbDiv;
  } cpc_cfg_t;

  typedef enum logic [2:0] {
    CPC_ST_RUN,
    CPC_ST_IDLE,
    CPC_ST_SLEEP,
    CPC_ST_PDOWN,
    CPC_ST_DEEP,
    CPC_ST_IRC_START,
    CPC_ST_RESUME,
    CPC_ST_RESET_REQ
  } cpc_state_t;

  typedef struct packed {
    logic     cpuRun;
    logic     flashReady;
    logic     flashPowerOn;
    logic     rcPowerOn;
    logic     rcOutEn;
    logic     mainOscOn;
    logic     mainStable;
    logic     pllPowerOn;
    logic     pllConnected;
    logic     pllLocked;
    logic     regulatorOn;
    logic     resetReq;
    cpc_src_t srcActive;
  } cpc_status_t;

endpackage

// *** rtl/cpc_clock_power_control.sv ***
// Overview of operation
// [RL1] After reset the clock source is the internal RC oscillator until software changes it.
// [RL2] Software selects RC, main or RTC oscillator as PLL input clock.
// [RL3] RC oscillator is 4 MHz; RC-derived timing counts assume that rate.
// [RL4] CPU clock is PLL input clock unless PLL is active and connected.
// [RL5] Every peripheral gets its own selectable clock through its own divider.
// [RL6] PLL input passes a pre-divider settable from 1 to 256.
// [RL7] Feedback divides oscillator by multiplier 1..32768 before phase comparison.
// [RL8] Software keeps controlled-oscillator frequency within 275 to 550 MHz.
// [RL9] PLL is disabled and bypassed on chip reset and Power-down entry.
// [RL10] Software configures, activates, waits lock, then connects the PLL.
// [RL11] Wake from Power-down runs from RC; software re-enables main or PLL.
// [RL12] Wake-up timer holds off main oscillator use until it is stable.
// [RL13] Idle stops execution until reset or interrupt; peripheral clocks keep running.
// [RL14] Sleep gates all clocks, disables RC output, keeps RTC and flash running.
// [RL15] Sleep entry disables and disconnects PLL, zeroes CPU and USB dividers.
// [RL16] Sleep ends only on reset or a clockless wake interrupt.
// [RL17] Sleep wake resumes after 4 RC cycles or 4096 main cycles.
// [RL18] Software reprograms PLL and dividers after Sleep or Power-down wake.
// [RL19] Power-down is Sleep plus RC oscillator and flash powered off.
// [RL20] Power-down wake allows 60 us RC start-up, then 4 RC cycles.
// [RL21] Flash wake counter counts RC cycles for 100 us before flash access.
// [RL22] Software can stop the clock of each peripheral individually.
// [RL23] Deep power-down wakes only on RTC alarm or reset, via full reset.
// [RL24] Source and PLL connection switching never make a short clock pulse.
`timescale 1ns/1ps
`default_nettype none
`include "cpc_consts.svh"

module cpc_clock_power_control #(
  parameter int NPERIPH = 4
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic                   cfgWr,
  input  wire cpc_pkg::cpc_cfg_t      cfg,
  input  wire logic                   idleReq,
  input  wire logic                   sleepReq,
  input  wire logic                   pdownReq,
  input  wire logic                   deepReq,
  input  wire logic [2*NPERIPH-1:0]   periphDivSel,
  input  wire logic [NPERIPH-1:0]     periphGateEn,
  input  wire logic                   rcOscIn,
  input  wire logic                   mainOscIn,
  input  wire logic                   rtcOscIn,
  input  wire logic                   ccoIn,
  input  wire logic                   pllLockIn,
  input  wire logic                   irqIn,
  input  wire logic                   wakeIrqIn,
  input  wire logic                   rtcAlarmIn,
  output var  logic                   cpuClkEn,
  output var  logic                   usbClkEn,
  output var  logic [NPERIPH-1:0]     periphClkEn,
  output var  logic                   pfdUp,
  output var  logic                   pfdDown,
  output var  cpc_pkg::cpc_status_t   status
);

  // [RL3] Flash count assumes 4 MHz RC; start-up count assumes 40 MHz clk_sys
  localparam logic [11:0] IRC_START_LAST = 12'(`CPC_IRC_START_CLKS - 64'h1);
  localparam logic [8:0]  FLASH_LAST     = 9'(`CPC_FLASH_WAKE_RC - 64'h1);

  logic [2:0]            sync_ff [`CPC_NPIN];
  logic [`CPC_NPIN-1:0]  lvl_ff;
  logic [`CPC_NPIN-1:0]  rise;

  cpc_pkg::cpc_src_t     srcReq_ff;
  cpc_pkg::cpc_src_t     srcAct_ff;
  logic                  mainOscEn_ff;
  logic                  pllEn_ff;
  logic                  pllConnReq_ff;
  logic [7:0]            preDiv_ff;
  logic [14:0]           mul_ff;
  logic [7:0]            cpuDiv_ff;
  logic [7:0]            usbDiv_ff;

  cpc_pkg::cpc_state_t   state_ff;
  cpc_pkg::cpc_state_t   nxt_state;
  logic [11:0]           wakeCnt_ff;
  logic                  priorMain_ff;

  logic                  cpuRun_ff;
  logic                  rcPowerOn_ff;
  logic                  rcOutEn_ff;
  logic                  regulatorOn_ff;
  logic                  resetReq_ff;
  logic                  flashPowerOn_ff;
  logic                  flashReady_ff;
  logic [8:0]            flashCnt_ff;
  logic                  mainOscOn_ff;
  logic                  mainStable_ff;
  logic [12:0]           mainCnt_ff;
  logic [7:0]            preCnt_ff;
  logic [14:0]           fbCnt_ff;
  logic                  pfdUp_ff;
  logic                  pfdDown_ff;
  logic                  pllLocked_ff;
  logic                  connAct_ff;
  logic [7:0]            cpuCnt_ff;
  logic [7:0]            usbCnt_ff;
  logic                  cpuClkEn_ff;
  logic                  usbClkEn_ff;

  logic                  rcTick;
  logic                  mainTick;
  logic                  ccoTick;
  logic                  reqTick;
  logic                  actTick;
  logic                  srcTick;
  logic                  refTick;
  logic                  fbTick;
  logic                  baseTick;
  logic                  cclkTick;
  logic                  usbTick;
  logic                  clocksOn;
  logic                  enterLow;
  logic                  enterPd;
  logic                  selAllowed;

  // Three-stage synchronisers; a level counts once stages two and three agree.
  for (genvar i = 0; i < `CPC_NPIN; i++) begin : g_sync
    always_ff @(posedge clk_sys) begin
      if (!rstn) begin
        sync_ff[i] <= 3'h0;
        lvl_ff[i]  <= 1'b0;
      end else begin
        sync_ff[i] <= {sync_ff[i][1:0], ((i == 0) ? rcOscIn :
                                         (i == 1) ? mainOscIn :
                                         (i == 2) ? rtcOscIn :
                                         (i == 3) ? ccoIn :
                                         (i == 4) ? pllLockIn :
                                         (i == 5) ? irqIn :
                                         (i == 6) ? wakeIrqIn : rtcAlarmIn)};
        if (sync_ff[i][2] == sync_ff[i][1]) begin
          lvl_ff[i] <= sync_ff[i][2];
        end
      end
    end
    assign rise[i] = (sync_ff[i][2] == sync_ff[i][1]) && sync_ff[i][2] && !lvl_ff[i];
  end

  // Oscillator pins are sampled, so each must run well below half of clk_sys;
  // the controlled oscillator arrives here already scaled down.
  assign rcTick   = rise[`CPC_PIN_RC] && rcOutEn_ff;
  assign mainTick = rise[`CPC_PIN_MAIN] && mainOscOn_ff;
  assign ccoTick  = rise[`CPC_PIN_CCO] && pllEn_ff;

  function automatic logic srcRise(input cpc_pkg::cpc_src_t s, input logic rc, input logic mn,
                                   input logic rt);
    case (s)
      cpc_pkg::CPC_SRC_RC:   srcRise = rc;
      cpc_pkg::CPC_SRC_MAIN: srcRise = mn;
      cpc_pkg::CPC_SRC_RTC:  srcRise = rt;
      default:               srcRise = 1'b0;
    endcase
  endfunction

  assign reqTick    = srcRise(srcReq_ff, rcTick, mainTick, rise[`CPC_PIN_RTC]);
  assign actTick    = srcRise(srcAct_ff, rcTick, mainTick, rise[`CPC_PIN_RTC]);
  // [RL24] Hold off old source
  assign srcTick    = actTick && (srcReq_ff == srcAct_ff);
  // [RL12] Main needs stability
  assign selAllowed = (srcReq_ff != cpc_pkg::CPC_SRC_MAIN) || mainStable_ff;

  assign enterLow = (state_ff == cpc_pkg::CPC_ST_RUN) &&
                    (nxt_state inside {cpc_pkg::CPC_ST_SLEEP, cpc_pkg::CPC_ST_PDOWN,
                                       cpc_pkg::CPC_ST_DEEP});
  assign enterPd  = (state_ff == cpc_pkg::CPC_ST_RUN) &&
                    (nxt_state inside {cpc_pkg::CPC_ST_PDOWN, cpc_pkg::CPC_ST_DEEP});
  assign clocksOn = (state_ff == cpc_pkg::CPC_ST_RUN) || (state_ff == cpc_pkg::CPC_ST_IDLE);

  // Configuration; low-power entry other than Idle overrides a write in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      // [RL1] RC after reset
      srcReq_ff     <= cpc_pkg::CPC_SRC_RC;
      mainOscEn_ff  <= 1'b0;
      // [RL9] PLL off, bypassed
      pllEn_ff      <= 1'b0;
      pllConnReq_ff <= 1'b0;
      preDiv_ff     <= 8'h00;
      mul_ff        <= 15'h0000;
      cpuDiv_ff     <= 8'h01;
      usbDiv_ff     <= 8'h00;
    end else if (enterLow) begin
      // [RL15] Sleep clears PLL
      pllEn_ff      <= 1'b0;
      pllConnReq_ff <= 1'b0;
      cpuDiv_ff     <= 8'h00;
      usbDiv_ff     <= 8'h00;
      if (enterPd) begin
        // [RL11] Power-down returns to RC
        srcReq_ff    <= cpc_pkg::CPC_SRC_RC;
        mainOscEn_ff <= 1'b0;
      end
    end else if (cfgWr) begin
      // [RL2] Source selector
      srcReq_ff     <= cfg.src;
      mainOscEn_ff  <= cfg.mainOscEn;
      pllEn_ff      <= cfg.pllEn;
      pllConnReq_ff <= cfg.pllConn;
      preDiv_ff     <= cfg.preDiv;
      mul_ff        <= cfg.mul;
      cpuDiv_ff     <= cfg.cpuDiv;
      usbDiv_ff     <= cfg.usbDiv;
    end
  end

  // Except on Power-down entry, which forces RC at once, the active source changes only on an edge of the new one, so no pulse is cut short.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      srcAct_ff <= cpc_pkg::CPC_SRC_RC;
    end else if (enterPd) begin
      srcAct_ff <= cpc_pkg::CPC_SRC_RC;
    end else if ((srcReq_ff != srcAct_ff) && selAllowed && reqTick) begin
      // [RL24] Switch on new edge
      srcAct_ff <= srcReq_ff;
    end
  end

  // [RL6] Pre-divider by N
  assign refTick = srcTick && pllEn_ff && (preCnt_ff == preDiv_ff);
  // [RL7] Feedback divide by M
  assign fbTick  = ccoTick && (fbCnt_ff == mul_ff);

  always_ff @(posedge clk_sys) begin
    if (!rstn || !pllEn_ff) begin
      preCnt_ff <= 8'h00;
      fbCnt_ff  <= 15'h0000;
    end else begin
      if (srcTick) begin
        preCnt_ff <= refTick ? 8'h00 : preCnt_ff + 8'h01;
      end
      if (ccoTick) begin
        fbCnt_ff <= fbTick ? 15'h0000 : fbCnt_ff + 15'h0001;
      end
    end
  end

  // [RL7] Phase-frequency detector
  always_ff @(posedge clk_sys) begin
    if (!rstn || !pllEn_ff) begin
      pfdUp_ff   <= 1'b0;
      pfdDown_ff <= 1'b0;
    end else if ((pfdUp_ff || refTick) && (pfdDown_ff || fbTick)) begin
      pfdUp_ff   <= 1'b0;
      pfdDown_ff <= 1'b0;
    end else begin
      pfdUp_ff   <= pfdUp_ff || refTick;
      pfdDown_ff <= pfdDown_ff || fbTick;
    end
  end

  // Connection follows request and enable, and needs lock to connect; it changes on an edge of the incoming clock except on low-power entry.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pllLocked_ff <= 1'b0;
      connAct_ff   <= 1'b0;
    end else begin
      pllLocked_ff <= pllEn_ff && lvl_ff[`CPC_PIN_LOCK];
      if (enterLow) begin
        connAct_ff <= 1'b0;
      end else if (!connAct_ff && pllConnReq_ff && pllLocked_ff && ccoTick) begin
        // [RL24] Connect on PLL edge
        connAct_ff <= 1'b1;
      end else if (connAct_ff && !(pllConnReq_ff && pllEn_ff) && actTick) begin
        connAct_ff <= 1'b0;
      end
    end
  end

  // [RL4] PLL only when active and connected
  assign baseTick = (connAct_ff && pllEn_ff) ? ccoTick : srcTick;
  assign cclkTick = baseTick && (cpuDiv_ff != 8'h00) && (cpuCnt_ff >= cpuDiv_ff - 8'h01);
  assign usbTick  = baseTick && (usbDiv_ff != 8'h00) && (usbCnt_ff >= usbDiv_ff - 8'h01);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cpuCnt_ff   <= 8'h00;
      usbCnt_ff   <= 8'h00;
      cpuClkEn_ff <= 1'b0;
      usbClkEn_ff <= 1'b0;
    end else begin
      if (baseTick) begin
        cpuCnt_ff <= cclkTick ? 8'h00 : cpuCnt_ff + 8'h01;
        usbCnt_ff <= usbTick ? 8'h00 : usbCnt_ff + 8'h01;
      end
      // [RL13] CPU clock stops in Idle
      cpuClkEn_ff <= cclkTick && clocksOn && cpuRun_ff;
      // [RL14] All clocks gated in Sleep
      usbClkEn_ff <= usbTick && clocksOn;
    end
  end

  // [RL5] Per-peripheral divider
  for (genvar p = 0; p < NPERIPH; p++) begin : g_periph
    cpc_periph_clk_div u_div (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .baseTick (cclkTick && clocksOn),
      // [RL22] Per-peripheral gate
      .gateEn   (periphGateEn[p]),
      .divSel   (periphDivSel[2*p +: 2]),
      .clkEn    (periphClkEn[p])
    );
  end

  // Power-mode sequencing; deeper requests win over lighter ones.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      cpc_pkg::CPC_ST_RUN: begin
        if (deepReq) begin
          nxt_state = cpc_pkg::CPC_ST_DEEP;
        end else if (pdownReq) begin
          nxt_state = cpc_pkg::CPC_ST_PDOWN;
        end else if (sleepReq) begin
          nxt_state = cpc_pkg::CPC_ST_SLEEP;
        end else if (idleReq) begin
          nxt_state = cpc_pkg::CPC_ST_IDLE;
        end
      end
      // [RL13] Idle ends on interrupt
      cpc_pkg::CPC_ST_IDLE: begin
        if (lvl_ff[`CPC_PIN_IRQ]) begin
          nxt_state = cpc_pkg::CPC_ST_RUN;
        end
      end
      // [RL16] Clockless wake only
      cpc_pkg::CPC_ST_SLEEP: begin
        if (lvl_ff[`CPC_PIN_WAKE]) begin
          nxt_state = cpc_pkg::CPC_ST_RESUME;
        end
      end
      cpc_pkg::CPC_ST_PDOWN: begin
        if (lvl_ff[`CPC_PIN_WAKE]) begin
          nxt_state = cpc_pkg::CPC_ST_IRC_START;
        end
      end
      // [RL20] RC start-up wait
      cpc_pkg::CPC_ST_IRC_START: begin
        if (wakeCnt_ff == IRC_START_LAST) begin
          nxt_state = cpc_pkg::CPC_ST_RESUME;
        end
      end
      // [RL17] Resume after 4 or 4096 cycles
      cpc_pkg::CPC_ST_RESUME: begin
        if (priorMain_ff ? mainStable_ff : (wakeCnt_ff[2:0] == `CPC_RC_WAKE_CYC)) begin
          nxt_state = cpc_pkg::CPC_ST_RUN;
        end
      end
      // [RL23] Only RTC alarm wakes
      cpc_pkg::CPC_ST_DEEP: begin
        if (lvl_ff[`CPC_PIN_ALARM]) begin
          nxt_state = cpc_pkg::CPC_ST_RESET_REQ;
        end
      end
      cpc_pkg::CPC_ST_RESET_REQ: nxt_state = cpc_pkg::CPC_ST_RESET_REQ;
      default:                   nxt_state = cpc_pkg::CPC_ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_ff     <= cpc_pkg::CPC_ST_RUN;
      wakeCnt_ff   <= 12'h000;
      priorMain_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff) begin
        wakeCnt_ff <= 12'h000;
      end else if (state_ff == cpc_pkg::CPC_ST_IRC_START) begin
        wakeCnt_ff <= wakeCnt_ff + 12'h001;
      end else if ((state_ff == cpc_pkg::CPC_ST_RESUME) && rcTick) begin
        wakeCnt_ff <= wakeCnt_ff + 12'h001;
      end
      if ((state_ff == cpc_pkg::CPC_ST_RUN) && (nxt_state == cpc_pkg::CPC_ST_SLEEP)) begin
        priorMain_ff <= (srcAct_ff == cpc_pkg::CPC_SRC_MAIN);
      end else if (enterPd) begin
        priorMain_ff <= 1'b0;
      end
    end
  end

  // Mode outputs follow the next state, so they change with the state register.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cpuRun_ff      <= 1'b1;
      rcPowerOn_ff   <= 1'b1;
      rcOutEn_ff     <= 1'b1;
      regulatorOn_ff <= 1'b1;
      resetReq_ff    <= 1'b0;
    end else begin
      cpuRun_ff      <= (nxt_state == cpc_pkg::CPC_ST_RUN);
      // [RL19] Power-down powers RC off
      rcPowerOn_ff   <= !(nxt_state inside {cpc_pkg::CPC_ST_PDOWN, cpc_pkg::CPC_ST_DEEP,
                                            cpc_pkg::CPC_ST_IRC_START});
      // [RL14] RC output off, power kept
      rcOutEn_ff     <= !(nxt_state inside {cpc_pkg::CPC_ST_SLEEP, cpc_pkg::CPC_ST_PDOWN,
                                            cpc_pkg::CPC_ST_DEEP, cpc_pkg::CPC_ST_IRC_START});
      regulatorOn_ff <= (nxt_state != cpc_pkg::CPC_ST_DEEP);
      // [RL23] Wake through full reset
      resetReq_ff    <= (nxt_state == cpc_pkg::CPC_ST_RESET_REQ);
    end
  end

  // [RL21] Flash wake counter
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      flashPowerOn_ff <= 1'b1;
      flashReady_ff   <= 1'b1;
      flashCnt_ff     <= 9'h000;
    end else if (enterPd) begin
      // [RL19] Flash powered off
      flashPowerOn_ff <= 1'b0;
      flashReady_ff   <= 1'b0;
      flashCnt_ff     <= 9'h000;
    end else begin
      if (nxt_state == cpc_pkg::CPC_ST_IRC_START) begin
        flashPowerOn_ff <= 1'b1;
      end
      if (flashPowerOn_ff && !flashReady_ff && rcTick) begin
        flashCnt_ff <= flashCnt_ff + 9'h001;
        if (flashCnt_ff == FLASH_LAST) begin
          flashReady_ff <= 1'b1;
        end
      end
    end
  end

  // [RL12] Main oscillator wake-up timer
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mainOscOn_ff  <= 1'b0;
      mainStable_ff <= 1'b0;
      mainCnt_ff    <= 13'h0000;
    end else begin
      mainOscOn_ff <= mainOscEn_ff && !(nxt_state inside {cpc_pkg::CPC_ST_SLEEP,
                                        cpc_pkg::CPC_ST_PDOWN, cpc_pkg::CPC_ST_DEEP});
      if (!mainOscOn_ff) begin
        mainStable_ff <= 1'b0;
        mainCnt_ff    <= 13'h0000;
      end else if (!mainStable_ff && mainTick) begin
        mainCnt_ff <= mainCnt_ff + 13'h0001;
        if (mainCnt_ff == `CPC_MAIN_WAKE_CYC - 13'h0001) begin
          mainStable_ff <= 1'b1;
        end
      end
    end
  end

  assign cpuClkEn = cpuClkEn_ff;
  assign usbClkEn = usbClkEn_ff;
  assign pfdUp    = pfdUp_ff;
  assign pfdDown  = pfdDown_ff;
  assign status   = '{cpuRun:       cpuRun_ff,
                      flashReady:   flashReady_ff,
                      flashPowerOn: flashPowerOn_ff,
                      rcPowerOn:    rcPowerOn_ff,
                      rcOutEn:      rcOutEn_ff,
                      mainOscOn:    mainOscOn_ff,
                      mainStable:   mainStable_ff,
                      pllPowerOn:   pllEn_ff,
                      pllConnected: connAct_ff,
                      pllLocked:    pllLocked_ff,
                      regulatorOn:  regulatorOn_ff,
                      resetReq:     resetReq_ff,
                      srcActive:    srcAct_ff};

endmodule

`default_nettype wire

// *** rtl/cpc_periph_clk_div.sv ***
`timescale 1ns/1ps
`default_nettype none

// One peripheral clock: gate plus divide by 1, 2, 4 or 8 of the base tick.
module cpc_periph_clk_div (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       baseTick,
  input  wire logic       gateEn,
  input  wire logic [1:0] divSel,
  output var  logic       clkEn
);

  logic [2:0] cnt_ff;
  logic [2:0] lastCnt;

  assign lastCnt = 3'((4'h1 << divSel) - 4'h1);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_ff <= 3'h0;
      clkEn  <= 1'b0;
    end else begin
      clkEn <= 1'b0;
      if (!gateEn) begin
        cnt_ff <= 3'h0;
      end else if (baseTick) begin
        if (cnt_ff >= lastCnt) begin
          cnt_ff <= 3'h0;
          clkEn  <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 3'h1;
        end
      end
    end
  end

endmodule

`default_nettype wire
